// [bench/bgeo_asserts.sv]
// Checker of bus, brake and encoder port behaviour
`timescale 1ns/1ps
`default_nettype none
module bgeo_asserts (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire logic                  hsel,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic                  hready,
    input wire logic [31:0]           hrdata,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire bgeo_pkg::bgeo_drive_t drive,
    input wire logic [15:0]           motor_speed,
    input wire logic                  zero_speed_flag,
    input wire logic                  brake_output,
    input wire logic                  enc_a,
    input wire logic                  enc_b,
    input wire logic                  index_pulse_output
);
    import bgeo_pkg::*;
    int         idx_cnt;
    wire logic  rd_take;
    wire logic [15:0] spd_abs;
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign spd_abs = motor_speed[15] ? -motor_speed : motor_speed;
    // Counts index high time so a short pulse shows at its falling edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) idx_cnt <= 0;
        else idx_cnt <= index_pulse_output ? idx_cnt + 1 : 0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_bus_ready: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not OKAY");
    a_rdata_idle: assert property (!$past(rd_take) |-> hrdata == 32'h0)
        else $error("hrdata not zero outside a read");
    a_index_min: assert property ($fell(index_pulse_output) |-> idx_cnt >= INDEX_MIN_CYCLES)
        else $error("index pulse too short");
    a_brake_norise: assert property ((!drive.servo_on)[*8] |-> !$rose(brake_output))
        else $error("brake rose while servo off");
    a_brake_zero: assert property ((!drive.servo_on && zero_speed_flag)[*8] |-> !brake_output)
        else $error("brake on at zero speed after servo off");
    a_speed_high: assert property ((spd_abs >= ZERO_SPEED_MAX)[*8] |-> !zero_speed_flag)
        else $error("zero speed flag at high speed");
    a_quad_edge: assert property (!($changed(enc_a) && $changed(enc_b)))
        else $error("both encoder phases moved together");
endmodule : bgeo_asserts
bind bgeo_top bgeo_asserts chk_u (.clk, .rst_n, .hsel, .htrans, .hwrite, .hready, .hrdata,
    .hreadyout, .hresp, .drive, .motor_speed, .zero_speed_flag, .brake_output, .enc_a,
    .enc_b, .index_pulse_output);
`default_nettype wire

// [bench/bgeo_host.sv]
// Host controller model sending command pulses and encoder feedback steps
`timescale 1ns/1ps
`default_nettype none
module bgeo_host (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       cmd_load,
    input  wire logic [7:0] cmd_n,
    input  wire logic       enc_go,
    output logic            cmd_pulse,
    output logic            cmd_dir,
    output logic            enc_step,
    output logic            enc_dir
);
    logic [7:0] cnt_reg;
    logic [2:0] ph_reg;
    assign cmd_dir = 1'b1;
    assign enc_dir = 1'b1;
    // One whole pulse per count; a load mid-phase still yields exactly one rise per count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 8'h0;
            ph_reg <= 3'h0;
            cmd_pulse <= 1'b0;
            enc_step <= 1'b0;
        end else begin
            ph_reg <= ph_reg + 3'h1;
            if (cmd_load) cnt_reg <= cmd_n;
            else if (ph_reg == 3'h7 && cnt_reg != 8'h0) cnt_reg <= cnt_reg - 8'h1;
            cmd_pulse <= (cnt_reg != 8'h0) && ph_reg[2];
            enc_step <= enc_go && ph_reg[1];
        end
    end
endmodule : bgeo_host
`default_nettype wire

// [bench/bgeo_top_tb.sv]
// Testbench of the brake, gear and encoder output block
`timescale 1ns/1ps
`default_nettype none
module bgeo_top_tb;
    import bgeo_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, cmd_load = 1'b0, enc_go = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] cmd_n = 8'h0;
    logic [15:0] motor_speed = 16'h0;
    bgeo_drive_t drive = '0;
    wire logic hreadyout, hresp, cmd_pulse, cmd_dir, enc_step, enc_dir, brake_output;
    wire logic zero_speed_flag, gear_pulse, gear_dir, enc_a, enc_b, index_pulse_output;
    int failures = 0, total_checks = 0, gear_cnt = 0;
    always #4 clk = ~clk;
    always @(posedge clk) if (gear_pulse === 1'b1) gear_cnt++;
    bgeo_top dut_u (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .drive, .motor_speed, .cmd_pulse,
        .cmd_dir, .enc_step(enc_step), .enc_dir, .brake_output, .zero_speed_flag, .gear_pulse,
        .gear_dir, .enc_a, .enc_b, .index_pulse_output);
    bgeo_host host_u (.clk, .rst_n, .cmd_load, .cmd_n, .enc_go, .cmd_pulse, .cmd_dir,
        .enc_step, .enc_dir);
    task stop_test;
        $display("failures=%0d total_checks=%0d", failures, total_checks);
        if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task wait_rdy;
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
        if (hreadyout !== 1'b1) begin failures++; stop_test; end
    endtask : wait_rdy
    task ahb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1; haddr <= {14'h0, a, 2'b00}; htrans <= HTRANS_NONSEQ; hwrite <= w;
        wait_rdy;
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        wait_rdy;
        r = hrdata;
    endtask : ahb
    task wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr
    task rc(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rc
    task wbrake(input logic v);
        int n;
        for (n = 0; n < 50 && brake_output !== v; n++) @(posedge clk);
        chk({31'h0, brake_output}, {31'h0, v});
        if (brake_output !== v) stop_test;
    endtask : wbrake
    task t_regs;
        rc(OFF_BRAKE_DELAY, RST_BRAKE_DELAY);
        rc(OFF_GEAR_NUM, RST_GEAR_NUM);
        rc(OFF_NUM_SEL_BASE + 16'h4, RST_GEAR_NUM);
        rc(OFF_GEAR_DEN, RST_GEAR_DEN);
        rc(OFF_ENC_PPR, RST_ENC_PPR);
        rc(OFF_ZERO_SPEED, {16'h0, RST_ZERO_SPEED});
        rc(16'h0190, 32'h0);
        wr(OFF_ENC_PPR, 32'h2);
        rc(OFF_ENC_PPR, ENC_PPR_MIN);
        wr(OFF_ENC_PPR, 32'hffff);
        rc(OFF_ENC_PPR, ENC_PPR_MAX);
        wr(OFF_GEAR_NUM, 32'hffff_ffff);
        rc(OFF_GEAR_NUM, GEAR_NUM_MAX);
        wr(OFF_GEAR_DEN, 32'h0);
        rc(OFF_GEAR_DEN, 32'h1);
        wr(OFF_GEAR_DEN, 32'ha);
    endtask : t_regs
    task t_gear;
        int g0, n;
        drive.servo_on <= 1'b1; drive.pt_mode <= 1'b1;
        wbrake(1'b1);
        wr(OFF_GEAR_DEN, 32'h14);
        rc(OFF_GEAR_DEN, 32'ha);
        wr(OFF_GEAR_NUM, 32'h5);
        rc(OFF_GEAR_NUM, 32'h5);
        g0 = gear_cnt;
        cmd_n <= 8'ha; cmd_load <= 1'b1;
        @(posedge clk); cmd_load <= 1'b0;
        for (n = 0; n < 400 && gear_cnt - g0 < 5; n++) @(posedge clk);
        repeat (40) @(posedge clk);
        chk(gear_cnt - g0, 32'h5);
        chk({31'h0, gear_dir}, 32'h1);
    endtask : t_gear
    task t_brake;
        wr(OFF_BRAKE_DELAY, 32'h1);
        motor_speed <= 16'h0bb8; drive.servo_on <= 1'b0;
        repeat (1000) @(posedge clk);
        chk({31'h0, brake_output}, 32'h1);
        chk({31'h0, zero_speed_flag}, 32'h0);
        motor_speed <= 16'h0;
        wbrake(1'b0);
        chk({31'h0, zero_speed_flag}, 32'h1);
        wr(OFF_BRAKE_DELAY, 32'h0000_fc18);
        motor_speed <= 16'hf448; drive.servo_on <= 1'b1;
        wbrake(1'b1);
        chk({31'h0, zero_speed_flag}, 32'h0);
        drive.emergency <= 1'b1; drive.servo_on <= 1'b0;
        wbrake(1'b0);
        drive.emergency <= 1'b0;
    endtask : t_brake
    task t_index;
        int n;
        wr(OFF_CTRL, 32'h1);
        wr(OFF_ENC_PPR, 32'h4);
        enc_go <= 1'b1;
        for (n = 0; n < 2000 && index_pulse_output !== 1'b1; n++) @(posedge clk);
        enc_go <= 1'b0;
        // High phase measured with steps stopped so it cannot retrigger
        for (n = 0; n < 40000 && index_pulse_output === 1'b1; n++) @(posedge clk);
        chk({31'h0, n >= INDEX_MIN_CYCLES && n < 40000}, 32'h1);
    endtask : t_index
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_gear;
        t_brake;
        t_index;
        stop_test;
    end
endmodule : bgeo_top_tb
`default_nettype wire

// [verilog/bgeo_brake.sv]
// Brake release timing after servo-off
`timescale 1ns/1ps
`default_nettype none
module bgeo_brake (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire bgeo_pkg::bgeo_drive_t drive,
    input  wire logic [15:0]         delay_ms,
    input  wire logic                zero_speed,
    output logic                     brake_output,
    output logic                     delay_running
);
    import bgeo_pkg::*;
    logic        servo_on_d_reg;
    logic [16:0] ms_left_reg;
    logic [31:0] tick_reg;
    logic        neg_delay;
    logic        forced_zero;
    logic [15:0] delay_eff;
    logic        off_edge;
    logic        tick_done;
    assign neg_delay   = delay_ms[15];
    // Alarm other than the excepted one, or emergency, drops a negative delay to zero
    assign forced_zero = neg_delay & (drive.emergency | (drive.alarm & ~drive.alarm_excepted));
    // Negative delay otherwise releases at once; limit to documented span
    assign delay_eff   = (neg_delay | forced_zero) ? 16'h0000 :
                         (delay_ms > DELAY_MS_MAX ? DELAY_MS_MAX : delay_ms);
    assign off_edge    = servo_on_d_reg & ~drive.servo_on;
    assign tick_done   = (tick_reg == 32'(MS_CYCLES - 1));
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            servo_on_d_reg <= 1'b0;
            ms_left_reg    <= 17'h00000;
            tick_reg       <= 32'h0000_0000;
            brake_output   <= 1'b0;
            delay_running  <= 1'b0;
        end else begin
            servo_on_d_reg <= drive.servo_on;
            if (drive.servo_on) begin
                brake_output  <= 1'b1;
                delay_running <= 1'b0;
            end else if (off_edge) begin
                ms_left_reg   <= {1'b0, delay_eff};
                tick_reg      <= 32'h0000_0000;
                delay_running <= (delay_eff != 16'h0000) & ~zero_speed;
                brake_output  <= (delay_eff != 16'h0000) & ~zero_speed;
            end else if (delay_running) begin
                if (zero_speed) begin
                    delay_running <= 1'b0;
                    brake_output  <= 1'b0;
                end else if (tick_done) begin
                    tick_reg <= 32'h0000_0000;
                    if (ms_left_reg <= 17'h00001) begin
                        delay_running <= 1'b0;
                        brake_output  <= 1'b0;
                    end
                    ms_left_reg <= ms_left_reg - 17'h00001;
                end else begin
                    tick_reg <= tick_reg + 32'h0000_0001;
                end
            end else begin
                brake_output <= 1'b0;
            end
        end
    end
endmodule : bgeo_brake
`default_nettype wire

// [verilog/bgeo_encoder.sv]
// Emulated encoder output with index pulse of minimum width
`timescale 1ns/1ps
`default_nettype none
module bgeo_encoder (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        quad,
    input  wire logic [31:0] ppr,
    input  wire logic        pos_step,
    input  wire logic        pos_dir,
    output logic             enc_a,
    output logic             enc_b,
    output logic             index_pulse_output
);
    import bgeo_pkg::*;
    logic [31:0] edges_rev;
    logic [31:0] ppr_lim;
    logic [31:0] edge_cnt_reg;
    logic [1:0]  phase_reg;
    logic [31:0] width_cnt_reg;
    logic [31:0] hold_cnt_reg;
    logic        index_hit;
    assign ppr_lim   = (ppr < ENC_PPR_MIN) ? ENC_PPR_MIN : (ppr > ENC_PPR_MAX ? ENC_PPR_MAX : ppr);
    // Count means single-phase pulses or edges after times-four decoding
    assign edges_rev = quad ? ppr_lim : {ppr_lim[29:0], 2'b00};
    assign index_hit = pos_step & (edge_cnt_reg == 32'h0000_0000);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_cnt_reg <= 32'h0000_0000;
            phase_reg    <= 2'b00;
        end else if (pos_step) begin
            phase_reg <= pos_dir ? phase_reg - 2'b01 : phase_reg + 2'b01;
            if (!pos_dir) begin
                edge_cnt_reg <= (edge_cnt_reg + 32'h1 >= edges_rev) ? 32'h0 : edge_cnt_reg + 32'h1;
            end else begin
                edge_cnt_reg <= (edge_cnt_reg == 32'h0) ? edges_rev - 32'h1 : edge_cnt_reg - 32'h1;
            end
        end
    end
    // Width is the INDEX_MIN_CYCLES floor unless a new index hit restarts it while high, as width_cnt_reg never exceeds hold_cnt_reg
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            width_cnt_reg      <= 32'h0000_0000;
            hold_cnt_reg       <= 32'h0000_0000;
            index_pulse_output <= 1'b0;
        end else begin
            if (pos_step) begin
                width_cnt_reg <= 32'h0000_0000;
            end else if (width_cnt_reg != 32'hffff_ffff) begin
                width_cnt_reg <= width_cnt_reg + 32'h1;
            end
            if (index_hit) begin
                index_pulse_output <= 1'b1;
                hold_cnt_reg       <= 32'h0000_0000;
            end else if (index_pulse_output) begin
                hold_cnt_reg <= hold_cnt_reg + 32'h1;
                // Ends at the floor, since hold_cnt_reg is never below width_cnt_reg
                if (hold_cnt_reg + 32'h1 >= 32'(INDEX_MIN_CYCLES) && pos_step) begin
                    index_pulse_output <= 1'b0;
                end else if (hold_cnt_reg + 32'h1 >= 32'(INDEX_MIN_CYCLES)
                             && hold_cnt_reg >= width_cnt_reg) begin
                    index_pulse_output <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enc_a <= 1'b0;
            enc_b <= 1'b0;
        end else begin
            enc_a <= phase_reg[1];
            enc_b <= phase_reg[1] ^ phase_reg[0];
        end
    end
endmodule : bgeo_encoder
`default_nettype wire

// [verilog/bgeo_pkg.sv]
// Package of constants and types for the brake, gear and encoder output block
package bgeo_pkg;
    // Register offsets are word indices; the bus byte address is four times the index
    localparam logic [15:0] OFF_BRAKE_DELAY    = 16'h0156;
    localparam logic [15:0] OFF_GEAR_NUM       = 16'h0158;
    localparam logic [15:0] OFF_GEAR_DEN       = 16'h015a;
    localparam logic [15:0] OFF_ENC_PPR        = 16'h015c;
    localparam logic [15:0] OFF_ZERO_SPEED     = 16'h0160;
    localparam logic [15:0] OFF_CTRL           = 16'h0164;
    localparam logic [15:0] OFF_NUM_SEL_BASE   = 16'h0170;
    localparam logic [15:0] OFF_STATUS         = 16'h0180;
    localparam logic [31:0] RST_BRAKE_DELAY    = 32'h0000_0000;
    localparam logic [31:0] RST_GEAR_NUM       = 32'h0000_0010;
    localparam logic [31:0] RST_GEAR_DEN       = 32'h0000_000a;
    localparam logic [31:0] RST_ENC_PPR        = 32'h0000_09c4;
    localparam logic [15:0] RST_ZERO_SPEED     = 16'h0064;
    localparam logic [31:0] GEAR_NUM_MAX       = 32'h03ff_ffff;
    localparam logic [31:0] GEAR_DEN_MAX       = 32'h7fff_ffff;
    localparam logic [31:0] ENC_PPR_MIN        = 32'h0000_0004;
    localparam logic [31:0] ENC_PPR_MAX        = 32'h0000_9c40;
    localparam logic [15:0] ZERO_SPEED_MAX     = 16'h07d0;
    localparam logic [15:0] DELAY_MS_MAX       = 16'h03e8;
    localparam int          CLK_MHZ            = 125;
    localparam int          MS_NS              = 1000000;
    localparam int          CLK_NS             = 8;
    localparam int          MS_CYCLES          = MS_NS / CLK_NS;
    localparam int          INDEX_MIN_US       = 250;
    localparam int          INDEX_MIN_CYCLES   = (INDEX_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int          CTRL_QUAD_BIT      = 0;
    localparam int          CTRL_NUM_SEL_LSB   = 1;
    localparam logic [1:0]  HTRANS_NONSEQ      = 2'b10;
    typedef struct packed {
        logic        servo_on;
        logic        pt_mode;
        logic        alarm;
        logic        alarm_excepted;
        logic        emergency;
    } bgeo_drive_t;
    typedef struct packed {
        logic [31:0] numerator;
        logic [31:0] denominator;
        logic        quad;
        logic [31:0] ppr;
    } bgeo_cfg_t;
endpackage : bgeo_pkg

// [verilog/bgeo_top.sv]
// Top of brake timing, electronic gear and encoder output with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module bgeo_top (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire bgeo_pkg::bgeo_drive_t drive,
    input  wire logic [15:0]           motor_speed,
    input  wire logic                  cmd_pulse,
    input  wire logic                  cmd_dir,
    input  wire logic                  enc_step,
    input  wire logic                  enc_dir,
    output logic                       brake_output,
    output logic                       zero_speed_flag,
    output logic                       gear_pulse,
    output logic                       gear_dir,
    output logic                       enc_a,
    output logic                       enc_b,
    output logic                       index_pulse_output
);
    import bgeo_pkg::*;
    logic [15:0]       brake_delay_reg;
    logic [31:0]       gear_num_reg [4];
    logic [31:0]       gear_den_reg;
    logic [31:0]       enc_ppr_reg;
    logic [15:0]       zero_speed_reg;
    logic [2:0]        ctrl_reg;
    logic              wr_pend_reg;
    logic [15:0]       wr_addr_reg;
    logic [1:0]        cmd_sync_reg;
    logic [1:0]        dir_sync_reg;
    logic [1:0]        step_sync_reg;
    logic [1:0]        edir_sync_reg;
    logic              cmd_last_reg;
    logic              step_last_reg;
    logic [31:0]       gear_acc_reg;
    logic              zero_speed_reg_q;
    bgeo_cfg_t         cfg_reg;
    bgeo_drive_t       drive_s1_reg;
    bgeo_drive_t       drive_s2_reg;
    logic              addr_ok;
    logic              den_locked;
    logic [15:0]       speed_abs;
    logic              zero_speed;
    logic              cmd_rise;
    logic              step_rise;
    logic [32:0]       acc_sum;
    logic              acc_over;
    logic [31:0]       num_sel;
    logic [31:0]       rd_mux;
    logic [15:0]       rd_addr;
    logic              brake_int;
    logic              delay_running;
    logic              index_int;
    logic              enc_a_int;
    logic              enc_b_int;
    logic [31:0]       wdata_num;
    logic [31:0]       wdata_den;
    logic [31:0]       wdata_ppr;
    logic [15:0]       wdata_zs;

    assign addr_ok    = hsel & hready & htrans[1];
    assign rd_addr    = haddr[17:2];
    assign den_locked = drive_s2_reg.servo_on & drive_s2_reg.pt_mode;
    assign wdata_num  = (hwdata == 32'h0) ? 32'h1 :
                        (hwdata > GEAR_NUM_MAX ? GEAR_NUM_MAX : hwdata);
    assign wdata_den  = (hwdata == 32'h0) ? 32'h1 :
                        (hwdata > GEAR_DEN_MAX ? GEAR_DEN_MAX : hwdata);
    assign wdata_ppr  = (hwdata < ENC_PPR_MIN) ? ENC_PPR_MIN :
                        (hwdata > ENC_PPR_MAX ? ENC_PPR_MAX : hwdata);
    assign wdata_zs   = (hwdata[15:0] > ZERO_SPEED_MAX) ? ZERO_SPEED_MAX : hwdata[15:0];

    // Registers answer with no wait state; writes land in the data phase
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 16'h0000;
        end else begin
            wr_pend_reg <= addr_ok & hwrite & (hsize == 3'b010);
            wr_addr_reg <= rd_addr;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brake_delay_reg <= RST_BRAKE_DELAY[15:0];
            gear_num_reg[0] <= RST_GEAR_NUM;
            gear_num_reg[1] <= RST_GEAR_NUM;
            gear_num_reg[2] <= RST_GEAR_NUM;
            gear_num_reg[3] <= RST_GEAR_NUM;
            gear_den_reg    <= RST_GEAR_DEN;
            enc_ppr_reg     <= RST_ENC_PPR;
            zero_speed_reg  <= RST_ZERO_SPEED;
            ctrl_reg        <= 3'b000;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == OFF_BRAKE_DELAY) begin
                brake_delay_reg <= hwdata[15:0];
            end
            // Numerators stay writable while running in pulse-train mode
            if (wr_addr_reg == OFF_GEAR_NUM) begin
                gear_num_reg[0] <= wdata_num;
            end
            for (int i = 1; i < 4; i++) begin
                if (wr_addr_reg == OFF_NUM_SEL_BASE + 16'(4 * i)) begin
                    gear_num_reg[i] <= wdata_num;
                end
            end
            if (wr_addr_reg == OFF_GEAR_DEN && !den_locked) begin
                gear_den_reg <= wdata_den;
            end
            if (wr_addr_reg == OFF_ENC_PPR) begin
                enc_ppr_reg <= wdata_ppr;
            end
            if (wr_addr_reg == OFF_ZERO_SPEED) begin
                zero_speed_reg <= wdata_zs;
            end
            if (wr_addr_reg == OFF_CTRL) begin
                ctrl_reg <= hwdata[2:0];
            end
        end
    end

    assign rd_mux = (rd_addr == OFF_BRAKE_DELAY)        ? {16'h0000, brake_delay_reg} :
                    (rd_addr == OFF_GEAR_NUM)           ? gear_num_reg[0] :
                    (rd_addr == OFF_NUM_SEL_BASE + 16'h4) ? gear_num_reg[1] :
                    (rd_addr == OFF_NUM_SEL_BASE + 16'h8) ? gear_num_reg[2] :
                    (rd_addr == OFF_NUM_SEL_BASE + 16'hc) ? gear_num_reg[3] :
                    (rd_addr == OFF_GEAR_DEN)           ? gear_den_reg :
                    (rd_addr == OFF_ENC_PPR)            ? enc_ppr_reg :
                    (rd_addr == OFF_ZERO_SPEED)         ? {16'h0000, zero_speed_reg} :
                    (rd_addr == OFF_CTRL)               ? {29'h0, ctrl_reg} :
                    (rd_addr == OFF_STATUS)             ? {28'h0, den_locked, delay_running,
                                                           zero_speed_reg_q, brake_int} :
                    32'h0000_0000;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= (addr_ok & ~hwrite) ? rd_mux : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Pulse, direction and drive inputs pass two flops before use; motor_speed passes one, as zero_speed_reg_q
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_sync_reg  <= 2'b00;
            dir_sync_reg  <= 2'b00;
            step_sync_reg <= 2'b00;
            edir_sync_reg <= 2'b00;
            drive_s1_reg  <= '0;
            drive_s2_reg  <= '0;
            cmd_last_reg  <= 1'b0;
            step_last_reg <= 1'b0;
        end else begin
            cmd_sync_reg  <= {cmd_sync_reg[0], cmd_pulse};
            dir_sync_reg  <= {dir_sync_reg[0], cmd_dir};
            step_sync_reg <= {step_sync_reg[0], enc_step};
            edir_sync_reg <= {edir_sync_reg[0], enc_dir};
            drive_s1_reg  <= drive;
            drive_s2_reg  <= drive_s1_reg;
            cmd_last_reg  <= cmd_sync_reg[1];
            step_last_reg <= step_sync_reg[1];
        end
    end
    assign cmd_rise  = cmd_sync_reg[1] & ~cmd_last_reg;
    assign step_rise = step_sync_reg[1] & ~step_last_reg;

    // Speed magnitude in 0.1 r/min, both directions
    assign speed_abs  = motor_speed[15] ? 16'(-motor_speed) : motor_speed;
    assign zero_speed = speed_abs < zero_speed_reg;

    // Settings are sampled every cycle so changes act without restart
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg          <= '{RST_GEAR_NUM, RST_GEAR_DEN, 1'b0, RST_ENC_PPR};
            zero_speed_reg_q <= 1'b0;
        end else begin
            cfg_reg.numerator   <= num_sel;
            cfg_reg.denominator <= gear_den_reg;
            cfg_reg.quad        <= ctrl_reg[CTRL_QUAD_BIT];
            cfg_reg.ppr         <= enc_ppr_reg;
            zero_speed_reg_q    <= zero_speed;
        end
    end
    assign num_sel = gear_num_reg[ctrl_reg[CTRL_NUM_SEL_LSB +: 2]];

    // Gear scaling: each command pulse adds N; one output pulse per M accumulated.
    // Ratio limits are the software's duty and are not checked here.
    assign acc_sum  = {1'b0, gear_acc_reg} + {1'b0, cfg_reg.numerator};
    // Compare the held sum alone so an idle accumulator never pulses
    assign acc_over = gear_acc_reg >= cfg_reg.denominator;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gear_acc_reg <= 32'h0000_0000;
            gear_pulse   <= 1'b0;
            gear_dir     <= 1'b0;
        end else begin
            gear_dir <= dir_sync_reg[1];
            if (cmd_rise) begin
                gear_acc_reg <= 32'(acc_sum);
                gear_pulse   <= 1'b0;
            end else if (acc_over) begin
                // One output pulse per cycle limits the ratio by command rate
                gear_acc_reg <= gear_acc_reg - cfg_reg.denominator;
                gear_pulse   <= 1'b1;
            end else begin
                gear_pulse <= 1'b0;
            end
        end
    end

    bgeo_brake u_brake (
        .clk           (clk),
        .rst_n         (rst_n),
        .drive         (drive_s2_reg),
        .delay_ms      (brake_delay_reg),
        .zero_speed    (zero_speed_reg_q),
        .brake_output  (brake_int),
        .delay_running (delay_running)
    );

    bgeo_encoder u_encoder (
        .clk                (clk),
        .rst_n              (rst_n),
        .quad               (cfg_reg.quad),
        .ppr                (cfg_reg.ppr),
        .pos_step           (step_rise),
        .pos_dir            (edir_sync_reg[1]),
        .enc_a              (enc_a_int),
        .enc_b              (enc_b_int),
        .index_pulse_output (index_int)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brake_output       <= 1'b0;
            zero_speed_flag    <= 1'b0;
            enc_a              <= 1'b0;
            enc_b              <= 1'b0;
            index_pulse_output <= 1'b0;
        end else begin
            brake_output       <= brake_int;
            zero_speed_flag    <= zero_speed_reg_q;
            enc_a              <= enc_a_int;
            enc_b              <= enc_b_int;
            index_pulse_output <= index_int;
        end
    end
endmodule : bgeo_top
`default_nettype wire
